// ---- logic/dual_gpio_ports.sv ----
// Purpose: two general purpose ports, 8-bit port a and 6-bit port b, on APB
// Assumes: one clock, synchronous active high reset, pins asynchronous
// Notes: pin outputs, input enables and special function lines are registered
// Behaviour
// R1: each port bit is input or output by its own direction bit
// R2: input pins pass two synchronising stages into the input register
// R3: written input bit of an input pin is resampled next cycle
// R4: output pins keep the software value in the input register
// R5: output pins are driven from the output value register
// R6: unused register bit of each pin holds its value, no effect
// R7: output register read returns held value, not pin level
// R8: input buffer disabled while the bit is an output
// R9: output register updates take effect on the rising clock edge
// R10: any register may be accessed at any time in any order
// R11: software clears special functions before direction changes, sets them last
// R12: port a direction bit 1 means output, 0 means input
// R13: port a output bits select push-pull or open-drain individually
// R14: port b has six independently configurable bidirectional lines
// R15: port b bit five only pulls low when output
// R16: port b special function register routes the alternate functions
// R17: low on port b bit zero as input with function selected recovers stop
// R18: after reset all bits are inputs and special functions are off
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dual_gpio_ports
    import gpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PA_W-1:0] pa_pin_in,
    output logic [PA_W-1:0] pa_pin_out,
    output logic [PA_W-1:0] pa_pin_oe,
    output logic [PA_W-1:0] pa_input_enable,
    input wire logic [PB_W-1:0] pb_pin_in,
    output logic [PB_W-1:0] pb_pin_out,
    output logic [PB_W-1:0] pb_pin_oe,
    output logic [PB_W-1:0] pb_input_enable,
    input wire logic timer_zero,
    output logic stop_mode_recovery,
    output logic interrupt_input_one,
    output logic interrupt_input_three,
    output logic interrupt_input_four,
    output logic comparator_reference,
    output logic comparator_signal,
    output logic irq
);
    typedef struct packed {
        logic [PA_W-1:0] pa_direction;
        logic [PA_W-1:0] pa_output_type;
        logic [PA_W-1:0] pa_output;
        logic [PB_W-1:0] pb_direction;
        logic [PB_W-1:0] pb_special;
        logic [PB_W-1:0] pb_output;
        logic [ST_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [PA_W-1:0] pa_drive;
        logic [PA_W-1:0] pa_enable;
        logic [PA_W-1:0] pa_in_en;
        logic [PB_W-1:0] pb_drive;
        logic [PB_W-1:0] pb_enable;
        logic [PB_W-1:0] pb_in_en;
        logic stop_rec;
        logic irq_one_four;
        logic irq_three;
        logic cmp_ref;
        logic cmp_sig;
    } top_s;

    top_s state_reg;
    top_s state_next;

    logic [PA_W-1:0] pa_sync;
    logic [PA_W-1:0] pa_value;
    logic [PB_W-1:0] pb_sync;
    logic [PB_W-1:0] pb_value;
    logic [ST_W-1:0] irq_status;
    logic irq_line;
    logic access_done;
    logic wr_done;
    logic wr_pa_input;
    logic wr_pb_input;
    logic status_read;
    logic [ST_W-1:0] events;
    logic [PB_W-1:0] pb_value_out;

    // transfer completes on the edge where the registered ready is seen
    assign access_done = psel & penable & state_reg.ready;
    assign wr_done = access_done & pwrite;
    assign wr_pa_input = wr_done & (paddr == ADDR_PA_INPUT); // R3
    assign wr_pb_input = wr_done & (paddr == ADDR_PB_INPUT); // R3
    assign status_read = access_done & ~pwrite & (paddr == ADDR_IRQ_STATUS);

    port_input_slice #(.W(PA_W)) u_pa_input (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in(pa_pin_in),
        .dir(state_reg.pa_direction),
        .wr_en(wr_pa_input),
        .wdata(pwdata[PA_W-1:0]),
        .sync_q(pa_sync),
        .value_q(pa_value)
    );

    port_input_slice #(.W(PB_W)) u_pb_input (
        .sys_clk(sys_clk),
        .reset(reset),
        .pin_in(pb_pin_in),
        .dir(state_reg.pb_direction),
        .wr_en(wr_pb_input),
        .wdata(pwdata[PB_W-1:0]),
        .sync_q(pb_sync),
        .value_q(pb_value)
    );

    irq_collect u_irq (
        .sys_clk(sys_clk),
        .reset(reset),
        .events(events),
        .rd_clr(status_read),
        .mask(state_reg.irq_mask),
        .status_q(irq_status),
        .irq_q(irq_line)
    );

    always_comb begin
        state_next = state_reg;
        events = '0;
        pb_value_out = '0;
        // apb slave: one wait cycle, then ready for one cycle
        state_next.ready = psel & penable & ~state_reg.ready; // R10
        state_next.slverr = 1'b0;
        if (psel & penable & ~state_reg.ready) begin
            case (paddr)
                ADDR_PA_INPUT: state_next.rdata = {24'h0, pa_value};
                ADDR_PA_OUTPUT: state_next.rdata = {24'h0, state_reg.pa_output}; // R7
                ADDR_PA_DIRECTION: state_next.rdata = {24'h0, state_reg.pa_direction};
                ADDR_PA_OUTPUT_TYPE: state_next.rdata = {24'h0, state_reg.pa_output_type};
                ADDR_PB_INPUT: state_next.rdata = {26'h0, pb_value};
                ADDR_PB_OUTPUT: state_next.rdata = {26'h0, state_reg.pb_output}; // R7
                ADDR_PB_DIRECTION: state_next.rdata = {26'h0, state_reg.pb_direction};
                ADDR_PB_SPECIAL: state_next.rdata = {26'h0, state_reg.pb_special};
                ADDR_IRQ_STATUS: state_next.rdata = {29'h0, irq_status};
                ADDR_IRQ_MASK: state_next.rdata = {29'h0, state_reg.irq_mask};
                default: begin
                    state_next.rdata = 32'h0000_0000;
                    state_next.slverr = 1'b1;
                end
            endcase
        end
        // output bits change only by software, never by pin activity
        if (wr_done) begin
            case (paddr)
                ADDR_PA_OUTPUT: state_next.pa_output = pwdata[PA_W-1:0]; // R6 R9
                ADDR_PA_DIRECTION: state_next.pa_direction = pwdata[PA_W-1:0]; // R1 R12
                ADDR_PA_OUTPUT_TYPE: state_next.pa_output_type = pwdata[PA_W-1:0]; // R13
                ADDR_PB_OUTPUT: state_next.pb_output = pwdata[PB_W-1:0]; // R6 R9
                ADDR_PB_DIRECTION: state_next.pb_direction = pwdata[PB_W-1:0]; // R1 R14
                ADDR_PB_SPECIAL: state_next.pb_special = pwdata[PB_W-1:0]; // R16
                ADDR_IRQ_MASK: state_next.irq_mask = pwdata[ST_W-1:0];
                default: begin
                end
            endcase
        end
        if (reset) begin
            state_next.pa_direction = RST_PA; // R18
            state_next.pa_output_type = RST_PA;
            state_next.pa_output = RST_PA;
            state_next.pb_direction = RST_PB; // R18
            state_next.pb_special = RST_PB; // R18
            state_next.pb_output = RST_PB;
            state_next.irq_mask = RST_ST;
            state_next.rdata = 32'h0000_0000;
            state_next.ready = 1'b0;
            state_next.slverr = 1'b0;
        end
        // port a: type bit 1 selects open drain
        state_next.pa_enable = state_next.pa_direction
            & (~state_next.pa_output_type | ~state_next.pa_output); // R5 R13
        state_next.pa_drive = state_next.pa_output & ~state_next.pa_output_type; // R5 R13
        state_next.pa_in_en = ~state_next.pa_direction; // R8
        // port b: timer output replaces bit one when selected
        pb_value_out = state_next.pb_output;
        if (state_next.pb_special[SF_TIMER_ZERO]) begin
            pb_value_out[SF_TIMER_ZERO] = timer_zero; // R16
        end
        state_next.pb_enable = state_next.pb_direction
            & ~(PB_OPEN_DRAIN_MASK & pb_value_out); // R5 R15
        state_next.pb_drive = pb_value_out & ~PB_OPEN_DRAIN_MASK; // R15
        state_next.pb_in_en = ~state_next.pb_direction; // R8
        // input special functions, only on input bits
        state_next.stop_rec = state_reg.pb_special[SF_STOP_RECOVERY]
            & ~state_reg.pb_direction[SF_STOP_RECOVERY] & ~pb_sync[SF_STOP_RECOVERY]; // R17
        state_next.irq_three = state_reg.pb_special[SF_IRQ_THREE]
            & ~state_reg.pb_direction[SF_IRQ_THREE] & ~pb_sync[SF_IRQ_THREE]; // R16
        state_next.irq_one_four = state_reg.pb_special[SF_CMP_SIGNAL]
            & ~state_reg.pb_direction[SF_CMP_SIGNAL] & ~pb_sync[SF_CMP_SIGNAL]; // R16
        state_next.cmp_ref = state_reg.pb_special[SF_CMP_REFERENCE]
            & ~state_reg.pb_direction[SF_CMP_REFERENCE] & pb_sync[SF_CMP_REFERENCE]; // R16
        state_next.cmp_sig = state_reg.pb_special[SF_CMP_SIGNAL]
            & ~state_reg.pb_direction[SF_CMP_SIGNAL] & pb_sync[SF_CMP_SIGNAL]; // R16
        if (reset) begin
            state_next.stop_rec = 1'b0;
            state_next.irq_three = 1'b0;
            state_next.irq_one_four = 1'b0;
            state_next.cmp_ref = 1'b0;
            state_next.cmp_sig = 1'b0;
        end else begin
            events[ST_STOP_RECOVERY] = state_next.stop_rec & ~state_reg.stop_rec;
            events[ST_IRQ_THREE] = state_next.irq_three & ~state_reg.irq_three;
            events[ST_IRQ_ONE_FOUR] = state_next.irq_one_four & ~state_reg.irq_one_four;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.slverr;
    assign pa_pin_out = state_reg.pa_drive;
    assign pa_pin_oe = state_reg.pa_enable;
    assign pa_input_enable = state_reg.pa_in_en;
    assign pb_pin_out = state_reg.pb_drive;
    assign pb_pin_oe = state_reg.pb_enable;
    assign pb_input_enable = state_reg.pb_in_en;
    assign stop_mode_recovery = state_reg.stop_rec;
    assign interrupt_input_one = state_reg.irq_one_four;
    assign interrupt_input_four = state_reg.irq_one_four;
    assign interrupt_input_three = state_reg.irq_three;
    assign comparator_reference = state_reg.cmp_ref;
    assign comparator_signal = state_reg.cmp_sig;
    assign irq = irq_line;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_OE_ONLY_OUTPUTS: assert property ((pa_pin_oe & ~state_reg.pa_direction) == '0 // R1 R12
        && (pb_pin_oe & ~state_reg.pb_direction) == '0)
        else $error("pin driven while set as input");
    AST_PUSH_PULL_VALUE: assert property (((pa_pin_out ^ state_reg.pa_output) // R5 R13
        & state_reg.pa_direction & ~state_reg.pa_output_type) == '0)
        else $error("push-pull pin does not follow output register");
    AST_OPEN_DRAIN_LOW: assert property ((pa_pin_oe & pa_pin_out & state_reg.pa_output_type) // R13
        == '0)
        else $error("open-drain pin driven high");
    AST_BIT_FIVE_NO_HIGH: assert property (pb_pin_oe[5] |-> !pb_pin_out[5]) // R15
        else $error("port b bit five driven high");
    AST_INPUT_ENABLE: assert property (pa_input_enable == ~state_reg.pa_direction // R8
        && pb_input_enable == ~state_reg.pb_direction)
        else $error("input buffer enabled on output");
    AST_RESET_INPUTS: assert property (disable iff (1'b0) reset ##1 1'b1 |-> // R18
        (pa_pin_oe == '0 && pb_pin_oe == '0 && state_reg.pb_special == '0))
        else $error("pin driven after reset");
    AST_DIR_WRITE: assert property ((wr_done && paddr == ADDR_PA_DIRECTION) |=> // R12 R10
        state_reg.pa_direction == $past(pwdata[PA_W-1:0]))
        else $error("direction write lost");
    AST_OUTPUT_READBACK: assert property ((psel && penable && !pready && !pwrite // R7
        && paddr == ADDR_PA_OUTPUT) |=> prdata == {24'h0, $past(state_reg.pa_output)})
        else $error("output register read mismatch");
    AST_OUTPUT_EDGE: assert property ((wr_done && paddr == ADDR_PA_OUTPUT) |=> // R9
        state_reg.pa_output == $past(pwdata[PA_W-1:0]))
        else $error("output register not updated at edge");
    AST_STOP_RECOVERY: assert property (stop_mode_recovery |-> // R17
        ($past(state_reg.pb_special[0]) && !$past(state_reg.pb_direction[0]) && !$past(pb_sync[0])))
        else $error("stop recovery without low input");
    AST_READY_ONE_WAIT: assert property ((psel && penable && !pready) |=> pready ##1 !pready) // R10
        else $error("apb answer timing wrong");
    // bus refusal, alternate function, input read and interrupt checks
    AST_ERROR_WITH_READY: assert property (pslverr |-> pready) // R10
        else $error("slave error without ready");
    AST_TIMER_ROUTE: assert property (state_reg.pb_special[SF_TIMER_ZERO] |-> // R16
        pb_pin_out[SF_TIMER_ZERO] == $past(timer_zero))
        else $error("timer output not routed to pin");
    AST_ONE_FOUR_PAIR: assert property (interrupt_input_one == interrupt_input_four) // R16
        else $error("interrupt inputs one and four differ");
    AST_CMP_ONLY_INPUT: assert property (comparator_reference |-> // R16
        !$past(state_reg.pb_direction[SF_CMP_REFERENCE]))
        else $error("comparator reference on output bit");
    AST_INPUT_READ: assert property ((psel && penable && !pready && !pwrite // R2
        && paddr == ADDR_PA_INPUT) |=> prdata == {24'h0, $past(pa_value)})
        else $error("input register read mismatch");
    AST_STOP_EVENT: assert property ($rose(stop_mode_recovery) |-> irq_status[ST_STOP_RECOVERY]) // R17
        else $error("stop recovery event not recorded");
    AST_IRQ_LEVEL: assert property (irq == ((irq_status & $past(state_reg.irq_mask)) != '0))
        else $error("interrupt level does not follow status");

    COV_DIR_WRITE: cover property (wr_done && paddr == ADDR_PA_DIRECTION);
    COV_STATUS_READ: cover property (status_read && irq_status != '0);
    COV_IRQ: cover property (irq);
    COV_OPEN_DRAIN: cover property ((pa_pin_oe & state_reg.pa_output_type) != '0);
    COV_TIMER_ROUTE: cover property (state_reg.pb_special[SF_TIMER_ZERO] && pb_pin_out[1]);
endmodule : dual_gpio_ports
`default_nettype wire

// ---- logic/gpio_pkg.sv ----
// Purpose: shared constants for the dual general purpose port block
// Assumes: APB word access, register index times four gives the byte address
// Notes: all reset values are zero so no pin drives after reset
package gpio_pkg;
    localparam int ADDR_W = 12;
    localparam int PA_W = 8;
    localparam int PB_W = 6;
    localparam int ST_W = 3;
    // register indices
    localparam logic [7:0] IDX_PA_INPUT = 8'hD0;
    localparam logic [7:0] IDX_PA_OUTPUT = 8'hD1;
    localparam logic [7:0] IDX_PA_DIRECTION = 8'hD2;
    localparam logic [7:0] IDX_PA_OUTPUT_TYPE = 8'hD3;
    localparam logic [7:0] IDX_PB_INPUT = 8'hD4;
    localparam logic [7:0] IDX_PB_OUTPUT = 8'hD5;
    localparam logic [7:0] IDX_PB_DIRECTION = 8'hD6;
    localparam logic [7:0] IDX_PB_SPECIAL = 8'hD7;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hD8;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hD9;
    // byte addresses
    localparam logic [ADDR_W-1:0] ADDR_PA_INPUT = {2'h0, IDX_PA_INPUT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PA_OUTPUT = {2'h0, IDX_PA_OUTPUT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PA_DIRECTION = {2'h0, IDX_PA_DIRECTION, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PA_OUTPUT_TYPE = {2'h0, IDX_PA_OUTPUT_TYPE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PB_INPUT = {2'h0, IDX_PB_INPUT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PB_OUTPUT = {2'h0, IDX_PB_OUTPUT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PB_DIRECTION = {2'h0, IDX_PB_DIRECTION, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PB_SPECIAL = {2'h0, IDX_PB_SPECIAL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
    // special function select fields
    localparam int SF_STOP_RECOVERY = 0;
    localparam int SF_TIMER_ZERO = 1;
    localparam int SF_IRQ_THREE = 2;
    localparam int SF_CMP_REFERENCE = 3;
    localparam int SF_CMP_SIGNAL = 4;
    // port b bit with no high side driver
    localparam logic [PB_W-1:0] PB_OPEN_DRAIN_MASK = 6'h20;
    // interrupt status fields
    localparam int ST_STOP_RECOVERY = 0;
    localparam int ST_IRQ_THREE = 1;
    localparam int ST_IRQ_ONE_FOUR = 2;
    // reset values
    localparam logic [PA_W-1:0] RST_PA = 8'h00;
    localparam logic [PB_W-1:0] RST_PB = 6'h00;
    localparam logic [ST_W-1:0] RST_ST = 3'h0;
endpackage : gpio_pkg

// ---- logic/irq_collect.sv ----
// Purpose: sticky event status with mask and one level interrupt
// Assumes: a read of the status register pulses rd_clr once
// Notes: an event in the clearing cycle is kept
`timescale 1ns/10ps
`default_nettype none
module irq_collect
    import gpio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [ST_W-1:0] events,
    input wire logic rd_clr,
    input wire logic [ST_W-1:0] mask,
    output logic [ST_W-1:0] status_q,
    output logic irq_q
);
    typedef struct packed {
        logic [ST_W-1:0] status;
        logic irq;
    } irq_s;

    irq_s state_reg;
    irq_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.status = (state_reg.status & ~{ST_W{rd_clr}}) | events;
        state_next.irq = |(state_next.status & mask);
        if (reset) begin
            state_next.status = RST_ST;
            state_next.irq = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign status_q = state_reg.status;
    assign irq_q = state_reg.irq;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_EVENT_NOT_LOST: assert property ((events != '0) |=> ((status_q & $past(events)) == $past(events)))
        else $error("event lost in status");
endmodule : irq_collect
`default_nettype wire

// ---- logic/port_input_slice.sv ----
// Purpose: pin synchroniser and software visible input register of one port
// Assumes: pins are asynchronous to sys_clk
// Notes: output bits keep their last software value
`timescale 1ns/10ps
`default_nettype none
module port_input_slice #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] dir,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] sync_q,
    output logic [W-1:0] value_q
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
        logic [W-1:0] value;
    } slice_s;

    slice_s state_reg;
    slice_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.stage1 = pin_in; // R2
        state_next.stage2 = state_reg.stage1; // R2
        if (wr_en) begin
            state_next.value = wdata; // R3
        end else begin
            state_next.value = (state_reg.value & dir) | (state_reg.stage2 & ~dir); // R3 R4
        end
        if (reset) begin
            state_next = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        state_reg <= state_next;
    end

    assign sync_q = state_reg.stage2;
    assign value_q = state_reg.value;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_INPUT_RESAMPLED: assert property (!wr_en |=> ((value_q ^ $past(sync_q)) & ~$past(dir)) == '0) // R3
        else $error("input bit not resampled");
    AST_OUTPUT_BIT_KEEPS: assert property (!wr_en |=> ((value_q ^ $past(value_q)) & $past(dir)) == '0) // R4
        else $error("output bit input register changed");
endmodule : port_input_slice
`default_nettype wire

// ---- tb/pin_partner.sv ----
// Purpose: external circuitry on the port pins, with a pull-up on every line
// Assumes: the bench commands which lines are driven from outside and to what level
// Notes: an outside driver beats the port driver, modelling a contention fault
`timescale 1ns/10ps
`default_nettype none
module pin_partner #(
    parameter int W = 8
) (
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] ext_en,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] level
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            // released line floats to the pull-up level
            level[i] = ext_en[i] ? ext_val[i] : (pin_oe[i] ? pin_out[i] : 1'b1);
        end
    end
endmodule : pin_partner
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the dual port block over APB
// Assumes: pin changes reach every register within six clock edges
// Notes: outside drive comes from two pin_partner instances
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import gpio_pkg::*;
    logic sys_clk;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, last_err, stop_rec, i1, i3, i4, cref, csig, irq;
    logic timer_zero = 1'b0;
    logic [PA_W-1:0] pa_in, pa_out, pa_oe, pa_ie;
    logic [PA_W-1:0] pa_en = 8'h00;
    logic [PA_W-1:0] pa_val = 8'h00;
    logic [PB_W-1:0] pb_in, pb_out, pb_oe, pb_ie;
    logic [PB_W-1:0] pb_en = 6'h00;
    logic [PB_W-1:0] pb_val = 6'h00;
    int err_total = 0;
    int compares = 0;

    dual_gpio_ports u_dut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_pin_in(pa_in), .pa_pin_out(pa_out), .pa_pin_oe(pa_oe),
        .pa_input_enable(pa_ie), .pb_pin_in(pb_in), .pb_pin_out(pb_out), .pb_pin_oe(pb_oe),
        .pb_input_enable(pb_ie), .timer_zero(timer_zero), .stop_mode_recovery(stop_rec),
        .interrupt_input_one(i1), .interrupt_input_three(i3), .interrupt_input_four(i4),
        .comparator_reference(cref), .comparator_signal(csig), .irq(irq));
    pin_partner #(.W(PA_W)) u_pa (.pin_out(pa_out), .pin_oe(pa_oe), .ext_en(pa_en),
        .ext_val(pa_val), .level(pa_in));
    pin_partner #(.W(PB_W)) u_pb (.pin_out(pb_out), .pin_oe(pb_oe), .ext_en(pb_en),
        .ext_val(pb_val), .level(pb_in));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(what, rv, e);
    endtask : rd_chk

    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask : settle

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        $display("ERROR watchdog expected done seen running");
        test_done();
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        chk("oe after reset", {18'h0, pa_oe, pb_oe}, 32'h0);
        chk("input enable after reset", {18'h0, pa_ie, pb_ie}, 32'h3FFF);
        chk("specials after reset", {26'h0, stop_rec, i1, i3, i4, cref, csig}, 32'h0);
        rd_chk("pa direction reset", ADDR_PA_DIRECTION, 32'h0);
        rd_chk("pb special reset", ADDR_PB_SPECIAL, 32'h0);
        $display("test reset done");
        pa_en <= 8'hFF;
        pa_val <= 8'hA5;
        settle();
        rd_chk("pa input sync", ADDR_PA_INPUT, 32'hA5);
        apb(1'b1, ADDR_PA_INPUT, 32'h5A);
        rd_chk("pa input resampled", ADDR_PA_INPUT, 32'hA5);
        $display("test input done");
        pa_en <= 8'hF0;
        apb(1'b1, ADDR_PA_OUTPUT, 32'h3C);
        apb(1'b1, ADDR_PA_DIRECTION, 32'h0F);
        chk("pa oe", {24'h0, pa_oe}, 32'h0F);
        chk("pa driven value", {24'h0, pa_out & pa_oe}, 32'h0C);
        chk("pa input enable", {24'h0, pa_ie}, 32'hF0);
        apb(1'b1, ADDR_PA_INPUT, 32'h03);
        settle();
        rd_chk("pa input mixed", ADDR_PA_INPUT, 32'hA3);
        rd_chk("pa output held", ADDR_PA_OUTPUT, 32'h3C);
        pa_en <= 8'hFF;
        pa_val <= 8'hF3;
        settle();
        rd_chk("pa output under contention", ADDR_PA_OUTPUT, 32'h3C);
        pa_en <= 8'hF0;
        apb(1'b1, ADDR_PA_OUTPUT_TYPE, 32'h03);
        apb(1'b1, ADDR_PA_OUTPUT, 32'h01);
        chk("pa open drain oe", {24'h0, pa_oe}, 32'h0E);
        chk("pa open drain level", {24'h0, pa_out & pa_oe}, 32'h00);
        $display("test port a done");
        apb(1'b1, ADDR_PB_OUTPUT, 32'h2A);
        apb(1'b1, ADDR_PB_DIRECTION, 32'h3F);
        chk("pb out high bit5", {26'h0, pb_out}, 32'h0A);
        chk("pb oe high bit5", {26'h0, pb_oe}, 32'h1F);
        apb(1'b1, ADDR_PB_OUTPUT, 32'h15);
        chk("pb out low bit5", {26'h0, pb_out & pb_oe}, 32'h15);
        chk("pb oe low bit5", {26'h0, pb_oe}, 32'h3F);
        apb(1'b1, ADDR_PB_DIRECTION, 32'h0A);
        chk("pb mixed oe", {26'h0, pb_oe}, 32'h0A);
        apb(1'b1, ADDR_PB_INPUT, 32'h3F);
        rd_chk("pb input mixed", ADDR_PB_INPUT, 32'h3F);
        $display("test port b done");
        apb(1'b1, ADDR_PB_SPECIAL, 32'h0);
        apb(1'b1, ADDR_PB_DIRECTION, 32'h02);
        apb(1'b1, ADDR_PB_SPECIAL, 32'h02);
        timer_zero <= 1'b1;
        @(posedge sys_clk);
        @(posedge sys_clk);
        chk("timer on pin high", {30'h0, pb_out[1], pb_oe[1]}, 32'h3);
        timer_zero <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        chk("timer on pin low", {31'h0, pb_out[1]}, 32'h0);
        apb(1'b1, ADDR_PB_SPECIAL, 32'h0);
        apb(1'b1, ADDR_PB_DIRECTION, 32'h0);
        pb_en <= 6'h3F;
        pb_val <= 6'h3F;
        apb(1'b1, ADDR_IRQ_MASK, 32'h7);
        apb(1'b1, ADDR_PB_SPECIAL, 32'h1D);
        settle();
        rd_chk("status clean", ADDR_IRQ_STATUS, 32'h0);
        chk("comparator lines high", {30'h0, cref, csig}, 32'h3);
        pb_val <= 6'h3E;
        settle();
        chk("stop recovery and irq", {30'h0, stop_rec, irq}, 32'h3);
        rd_chk("status recovery", ADDR_IRQ_STATUS, 32'h1);
        @(posedge sys_clk);
        chk("irq after clear", {31'h0, irq}, 32'h0);
        rd_chk("status cleared", ADDR_IRQ_STATUS, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        pb_val <= 6'h23;
        settle();
        chk("irq lines low pins", {28'h0, i3, i1, i4, csig}, 32'hE);
        chk("comparator reference low", {30'h0, cref, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h4);
        @(posedge sys_clk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        rd_chk("status masked events", ADDR_IRQ_STATUS, 32'h6);
        rd_chk("irq mask readback", ADDR_IRQ_MASK, 32'h4);
        $display("test special done");
        rd_chk("unmapped read", 12'h000, 32'h0);
        chk("unmapped error", {31'h0, last_err}, 32'h1);
        apb(1'b1, 12'hFFC, 32'hFF);
        rd_chk("pa output after unmapped", ADDR_PA_OUTPUT, 32'h01);
        $display("test unmapped done");
        test_done();
    end
endmodule : tb_top
`default_nettype wire
